// >>> hdl/ssbd_regs.vh
// constants of the bus-slave command decoder: command codes, register layouts, reset values, bus map
// assumes inclusion by every design file of the decoder
`ifndef SSBD_REGS_VH
`define SSBD_REGS_VH

// framing bytes
`define SSBD_FRM_HI5 5'h1C
`define SSBD_FRM_RPL_A 8'hE2
`define SSBD_FRM_RPL_B 8'hE3
`define SSBD_FRM_REPLY_OK 8'hE4

// address bytes
`define SSBD_ADR_ANY 8'h00
`define SSBD_ADR_ANY_OUTDOOR 8'h10
`define SSBD_ADR_LNB 8'h11
`define SSBD_ADR_SWITCH 8'h14

// command bytes
`define SSBD_CMD_RESET 8'h00
`define SSBD_CMD_CLR_RESET 8'h01
`define SSBD_CMD_SET_CONTEND 8'h04
`define SSBD_CMD_CONTEND 8'h05
`define SSBD_CMD_CLR_CONTEND 8'h06
`define SSBD_CMD_ADDRESS 8'h07
`define SSBD_CMD_MOVE_C 8'h08
`define SSBD_CMD_MOVE 8'h09
`define SSBD_CMD_STATUS 8'h10
`define SSBD_CMD_CONFIG 8'h11
`define SSBD_CMD_SWITCH 8'h14
`define SSBD_CMD_SET_LO 8'h20
`define SSBD_CMD_SET_VR 8'h21
`define SSBD_CMD_SET_POS_A 8'h22
`define SSBD_CMD_SET_OPT_A 8'h23
`define SSBD_CMD_SET_HI 8'h24
`define SSBD_CMD_SET_HL 8'h25
`define SSBD_CMD_SET_POS_B 8'h26
`define SSBD_CMD_SET_OPT_B 8'h27
`define SSBD_CMD_SLEEP 8'h30
`define SSBD_CMD_AWAKE 8'h31
`define SSBD_CMD_WRITE_N0 8'h38
`define SSBD_CMD_LO_STRING 8'h50
`define SSBD_CMD_LO_NOW 8'h51
`define SSBD_CMD_LO_LO 8'h52
`define SSBD_CMD_LO_HI 8'h53

// status register fields and reset value
`define SSBD_ST_RESET 0
`define SSBD_ST_SLEEP 1
`define SSBD_ST_VOLT 2
`define SSBD_ST_CONTEND 7
`define SSBD_ST_RST_VAL 8'h01

// configuration register (read only)
`define SSBD_CFG_VAL 8'h03

// switching-state register fields
`define SSBD_SW_BAND 4
`define SSBD_SW_POL 5
`define SSBD_SW_SAT 6
`define SSBD_SW_OPT 7
`define SSBD_SW_OPT_AVAIL 3
`define SSBD_SW_FIXED 3'h7
`define SSBD_SW_SEL_RST 4'h0

// oscillator frequency bytes
`define SSBD_LOW_OSC_B2 8'h09
`define SSBD_LOW_OSC_B1 8'h75
`define SSBD_LOW_OSC_B0 8'h02
`define SSBD_HIGH_OSC_B2 8'h10
`define SSBD_HIGH_OSC_B1 8'h60
`define SSBD_HIGH_OSC_B0 8'h04

// software register map (byte addresses)
`define SSBD_REG_CTRL 4'h0
`define SSBD_REG_STAT 4'h4
`define SSBD_CTRL_LNB 0
`define SSBD_CTRL_CASC 1
`define SSBD_CTRL_RECON 2
`define SSBD_CTRL_RST_VAL 2'h0

// AXI responses
`define SSBD_RESP_OKAY 2'h0
`define SSBD_RESP_SLVERR 2'h2

`endif

// >>> hdl/ssbd_decoder.v
// command decoder of one receiver port of the satellite IF switch, with AXI4-Lite control
// assumes frame bytes arrive already demodulated on this clock; reply bytes leave to a modulator
//
// Notes on behaviour
// RULE1: accept framing bytes E0 through E7
// RULE2: act on addresses 00, 10, own address
// RULE3: third byte is command, fourth its data
// RULE4: reply only for framing E2 or E3
// RULE5: 00 reinitialises, 01 clears reset flag
// RULE6: 04 sets contention flag, 06 clears it
// RULE7: 05/07 return address per contention flag
// RULE8: 08/09 write address per contention flag
// RULE9: 10, 11, 14 return status, config, switch
// RULE10: 20 clears band bit, 24 sets it
// RULE11: 21 clears polarization bit, 25 sets it
// RULE12: 22 clears satellite bit, 26 sets it
// RULE13: 23 clears option bit, 27 sets it
// RULE14: sleep ignores all commands except awake
// RULE15: 38 data byte writes switch bits 7:4
// RULE16: 50 returns two oscillator bytes per band
// RULE17: 51/52/53 return oscillator table entry nibble
// RULE18: route input sat*4+band*2+pol+1
// RULE19: option set takes the chained input path
// RULE20: after reset input one selected
// RULE21: master sends only differing selection commands
// RULE22: named registers have no bus address
// RULE23: first valid frame moves to bus control
// RULE24: lnb mode ignores switcher address, single opposite
// RULE25: bad frames change nothing, no reply
`timescale 1ns/1ps
`include "ssbd_regs.vh"

module ssbd_decoder (
  input wire I_CLK_SYS,
  input wire I_RESET_N,
  input wire [3:0] I_AWADDR,
  input wire I_AWVALID,
  output wire O_AWREADY,
  input wire [31:0] I_WDATA,
  input wire [3:0] I_WSTRB,
  input wire I_WVALID,
  output wire O_WREADY,
  output wire [1:0] O_BRESP,
  output wire O_BVALID,
  input wire I_BREADY,
  input wire [3:0] I_ARADDR,
  input wire I_ARVALID,
  output wire O_ARREADY,
  output wire [31:0] O_RDATA,
  output wire [1:0] O_RRESP,
  output wire O_RVALID,
  input wire I_RREADY,
  input wire I_RX_VALID,
  input wire [7:0] I_RX_BYTE,
  input wire I_RX_END,
  output wire O_TX_VALID,
  output wire [7:0] O_TX_BYTE,
  output wire O_TX_LAST,
  input wire I_TX_READY,
  input wire I_VOLT_HIGH,
  output wire [2:0] O_RF_SEL,
  output wire O_CHAIN_SEL,
  output wire O_BUS_CTRL
);

  // bus slave state
  reg awready_ff, wready_ff, bvalid_ff, arready_ff, rvalid_ff;
  reg aw_hold_ff, w_hold_ff;
  reg [3:0] awaddr_ff;
  reg [7:0] wdata_ff;
  reg wstrb0_ff;
  reg [1:0] bresp_ff, rresp_ff;
  reg [31:0] rdata_ff;
  reg [1:0] ctrl_ff;
  reg ctrl_wr_ff;
  reg recon_ff;
  reg [7:0] frame_cnt_ff;

  // frame capture and named registers
  reg [2:0] cnt_ff;
  reg [7:0] b0_ff, b1_ff, b2_ff, b3_ff;
  reg exec_ff;
  reg [7:0] stat_ff, sw_ff, addr_ff;
  reg bus_ctrl_ff;
  reg [2:0] rf_sel_ff;
  reg chain_sel_ff;
  reg volt_s1_ff, volt_s2_ff, volt_s3_ff, volt_ff;

  // reply shifter
  reg tx_valid_ff, tx_last_ff;
  reg [7:0] tx_byte_ff, tx_d1_ff, tx_d2_ff;
  reg [1:0] tx_left_ff;

  reg [7:0] nxt_stat, nxt_sw, nxt_addr, nxt_d1, nxt_d2;
  reg [1:0] nxt_len;
  reg hit;
  wire [7:0] cmd = b2_ff;
  wire lnb_mode = ctrl_ff[`SSBD_CTRL_LNB];
  wire [7:0] dflt_addr = lnb_mode ? `SSBD_ADR_LNB : `SSBD_ADR_SWITCH;
  wire tx_busy = tx_valid_ff | exec_ff;
  wire addr_ok = ((b1_ff == `SSBD_ADR_ANY) || (b1_ff == `SSBD_ADR_ANY_OUTDOOR) || (b1_ff == addr_ff)) && // RULE2
    !(lnb_mode && b1_ff == `SSBD_ADR_SWITCH) && !(!lnb_mode && b1_ff == `SSBD_ADR_LNB); // RULE24
  wire frame_ok = (cnt_ff >= 3'd3) && (b0_ff[7:3] == `SSBD_FRM_HI5) && addr_ok; // RULE1 RULE25
  wire has_data = (cnt_ff >= 3'd4);
  wire want_reply = (b0_ff == `SSBD_FRM_RPL_A) || (b0_ff == `SSBD_FRM_RPL_B);
  wire contend = stat_ff[`SSBD_ST_CONTEND];
  wire high_band = sw_ff[`SSBD_SW_BAND];
  wire [7:0] sw_view = {sw_ff[7:4], ctrl_ff[`SSBD_CTRL_CASC], `SSBD_SW_FIXED};
  wire [7:0] nib_low = `SSBD_LOW_OSC_B0 & 8'h0F;
  wire [7:0] nib_high = `SSBD_HIGH_OSC_B0 & 8'h0F;
  wire [3:0] n0_sel;

  // port group 0: high nibble of the data enables, low nibble gives the value
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_n0
      assign n0_sel[g] = b3_ff[4 + g] ? b3_ff[g] : sw_ff[4 + g]; // RULE15
    end
  endgenerate

  always @* begin
    nxt_stat = stat_ff;
    nxt_sw = sw_ff;
    nxt_addr = addr_ff;
    nxt_len = 2'd0;
    nxt_d1 = 8'h00;
    nxt_d2 = 8'h00;
    hit = 1'b0;
    // sleeping decoder answers only the awake command
    if (exec_ff && frame_ok && (!stat_ff[`SSBD_ST_SLEEP] || cmd == `SSBD_CMD_AWAKE)) begin // RULE14
      hit = 1'b1;
      nxt_len = 2'd1;
      case (cmd) // RULE3
        `SSBD_CMD_RESET: begin
          nxt_stat = `SSBD_ST_RST_VAL; // RULE5
          nxt_sw[7:4] = `SSBD_SW_SEL_RST;
          nxt_addr = dflt_addr;
        end
        `SSBD_CMD_CLR_RESET: nxt_stat[`SSBD_ST_RESET] = 1'b0; // RULE5
        `SSBD_CMD_SET_CONTEND: nxt_stat[`SSBD_ST_CONTEND] = 1'b1; // RULE6
        `SSBD_CMD_CLR_CONTEND: nxt_stat[`SSBD_ST_CONTEND] = 1'b0; // RULE6
        `SSBD_CMD_CONTEND: begin
          nxt_len = contend ? 2'd2 : 2'd1; // RULE7
          nxt_d1 = addr_ff;
        end
        `SSBD_CMD_ADDRESS: begin
          nxt_len = contend ? 2'd1 : 2'd2; // RULE7
          nxt_d1 = addr_ff;
        end
        `SSBD_CMD_MOVE_C: begin
          if (!has_data) begin
            hit = 1'b0;
            nxt_len = 2'd0;
          end else if (contend) begin
            nxt_addr = b3_ff; // RULE8
          end
        end
        `SSBD_CMD_MOVE: begin
          if (!has_data) begin
            hit = 1'b0;
            nxt_len = 2'd0;
          end else if (!contend) begin
            nxt_addr = b3_ff; // RULE8
          end
        end
        `SSBD_CMD_STATUS: begin
          nxt_len = 2'd2; // RULE9
          nxt_d1 = stat_ff;
        end
        `SSBD_CMD_CONFIG: begin
          nxt_len = 2'd2; // RULE9
          nxt_d1 = `SSBD_CFG_VAL;
        end
        `SSBD_CMD_SWITCH: begin
          nxt_len = 2'd2; // RULE9
          nxt_d1 = sw_view;
        end
        `SSBD_CMD_SET_LO: nxt_sw[`SSBD_SW_BAND] = 1'b0; // RULE10 RULE21
        `SSBD_CMD_SET_HI: nxt_sw[`SSBD_SW_BAND] = 1'b1; // RULE10
        `SSBD_CMD_SET_VR: nxt_sw[`SSBD_SW_POL] = 1'b0; // RULE11
        `SSBD_CMD_SET_HL: nxt_sw[`SSBD_SW_POL] = 1'b1; // RULE11
        `SSBD_CMD_SET_POS_A: nxt_sw[`SSBD_SW_SAT] = 1'b0; // RULE12
        `SSBD_CMD_SET_POS_B: nxt_sw[`SSBD_SW_SAT] = 1'b1; // RULE12
        `SSBD_CMD_SET_OPT_A: nxt_sw[`SSBD_SW_OPT] = 1'b0; // RULE13
        `SSBD_CMD_SET_OPT_B: nxt_sw[`SSBD_SW_OPT] = 1'b1; // RULE13
        `SSBD_CMD_SLEEP: nxt_stat[`SSBD_ST_SLEEP] = 1'b1; // RULE14
        `SSBD_CMD_AWAKE: nxt_stat[`SSBD_ST_SLEEP] = 1'b0; // RULE14
        `SSBD_CMD_WRITE_N0: begin
          if (has_data) begin
            nxt_sw[7:4] = n0_sel; // RULE15
          end else begin
            hit = 1'b0;
            nxt_len = 2'd0;
          end
        end
        `SSBD_CMD_LO_STRING: begin
          nxt_len = 2'd3; // RULE16
          nxt_d1 = high_band ? `SSBD_HIGH_OSC_B2 : `SSBD_LOW_OSC_B2;
          nxt_d2 = high_band ? `SSBD_HIGH_OSC_B1 : `SSBD_LOW_OSC_B1;
        end
        `SSBD_CMD_LO_NOW: begin
          nxt_len = 2'd2; // RULE17
          nxt_d1 = high_band ? nib_high : nib_low;
        end
        `SSBD_CMD_LO_LO: begin
          nxt_len = 2'd2; // RULE17
          nxt_d1 = nib_low;
        end
        `SSBD_CMD_LO_HI: begin
          nxt_len = 2'd2; // RULE17
          nxt_d1 = nib_high;
        end
        default: begin
          hit = 1'b0; // RULE25
          nxt_len = 2'd0;
        end
      endcase
      if (!want_reply) begin
        nxt_len = 2'd0; // RULE4
      end
    end
    // a mode change from software reloads the default own address
    if (ctrl_wr_ff) begin
      nxt_addr = dflt_addr;
    end
    nxt_stat[6:3] = 4'h0;
    nxt_stat[`SSBD_ST_VOLT] = volt_ff;
  end

  // supply level pin: three stages, change taken once stages two and three agree
  always @(posedge I_CLK_SYS or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      volt_s1_ff <= 1'b0;
      volt_s2_ff <= 1'b0;
      volt_s3_ff <= 1'b0;
      volt_ff <= 1'b0;
    end else begin
      volt_s1_ff <= I_VOLT_HIGH;
      volt_s2_ff <= volt_s1_ff;
      volt_s3_ff <= volt_s2_ff;
      if (volt_s2_ff == volt_s3_ff) begin
        volt_ff <= volt_s3_ff;
      end
    end
  end

  // frame capture; bytes arriving while a frame executes or a reply is out are dropped
  always @(posedge I_CLK_SYS or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      cnt_ff <= 3'd0;
      b0_ff <= 8'h00;
      b1_ff <= 8'h00;
      b2_ff <= 8'h00;
      b3_ff <= 8'h00;
      exec_ff <= 1'b0;
    end else begin
      exec_ff <= I_RX_END & ~tx_busy;
      if (exec_ff) begin
        cnt_ff <= 3'd0;
      end else if (I_RX_VALID && !tx_busy) begin
        case (cnt_ff)
          3'd0: b0_ff <= I_RX_BYTE;
          3'd1: b1_ff <= I_RX_BYTE;
          3'd2: b2_ff <= I_RX_BYTE;
          3'd3: b3_ff <= I_RX_BYTE;
          default: b3_ff <= b3_ff;
        endcase
        if (cnt_ff != 3'd7) begin
          cnt_ff <= cnt_ff + 3'd1;
        end
      end
    end
  end

  // named registers, routing and control mode
  always @(posedge I_CLK_SYS or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      stat_ff <= `SSBD_ST_RST_VAL;
      sw_ff <= {`SSBD_SW_SEL_RST, 4'h0}; // RULE20
      addr_ff <= `SSBD_ADR_SWITCH;
      bus_ctrl_ff <= 1'b0;
      rf_sel_ff <= 3'd0;
      chain_sel_ff <= 1'b0;
      frame_cnt_ff <= 8'h00;
    end else begin
      stat_ff <= nxt_stat; // RULE22
      sw_ff <= nxt_sw;
      addr_ff <= nxt_addr;
      // a valid frame wins over a reconnect in the same cycle
      if (hit) begin
        bus_ctrl_ff <= 1'b1; // RULE23
        frame_cnt_ff <= frame_cnt_ff + 8'h01;
      end else if (recon_ff) begin
        bus_ctrl_ff <= 1'b0; // RULE23
      end
      rf_sel_ff <= {sw_ff[`SSBD_SW_SAT], sw_ff[`SSBD_SW_BAND], sw_ff[`SSBD_SW_POL]}; // RULE18
      chain_sel_ff <= sw_ff[`SSBD_SW_OPT]; // RULE19
    end
  end

  // reply shifter: reply framing byte first, then up to two data bytes
  always @(posedge I_CLK_SYS or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      tx_valid_ff <= 1'b0;
      tx_last_ff <= 1'b0;
      tx_byte_ff <= 8'h00;
      tx_d1_ff <= 8'h00;
      tx_d2_ff <= 8'h00;
      tx_left_ff <= 2'd0;
    end else if (nxt_len != 2'd0) begin
      tx_valid_ff <= 1'b1; // RULE4
      tx_last_ff <= (nxt_len == 2'd1);
      tx_byte_ff <= `SSBD_FRM_REPLY_OK;
      tx_d1_ff <= nxt_d1;
      tx_d2_ff <= nxt_d2;
      tx_left_ff <= nxt_len;
    end else if (tx_valid_ff && I_TX_READY) begin
      tx_byte_ff <= tx_d1_ff;
      tx_d1_ff <= tx_d2_ff;
      tx_left_ff <= tx_left_ff - 2'd1;
      tx_last_ff <= (tx_left_ff == 2'd2);
      if (tx_left_ff == 2'd1) begin
        tx_valid_ff <= 1'b0;
      end
    end
  end

  // AXI4-Lite write: address and data taken in either order, response after both
  always @(posedge I_CLK_SYS or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      awready_ff <= 1'b1;
      wready_ff <= 1'b1;
      bvalid_ff <= 1'b0;
      aw_hold_ff <= 1'b0;
      w_hold_ff <= 1'b0;
      awaddr_ff <= 4'h0;
      wdata_ff <= 8'h00;
      wstrb0_ff <= 1'b0;
      bresp_ff <= `SSBD_RESP_OKAY;
      ctrl_ff <= `SSBD_CTRL_RST_VAL;
      ctrl_wr_ff <= 1'b0;
      recon_ff <= 1'b0;
    end else begin
      ctrl_wr_ff <= 1'b0;
      recon_ff <= 1'b0;
      if (awready_ff && I_AWVALID) begin
        awready_ff <= 1'b0;
        aw_hold_ff <= 1'b1;
        awaddr_ff <= I_AWADDR;
      end
      if (wready_ff && I_WVALID) begin
        wready_ff <= 1'b0;
        w_hold_ff <= 1'b1;
        wdata_ff <= I_WDATA[7:0];
        wstrb0_ff <= I_WSTRB[0];
      end
      if (aw_hold_ff && w_hold_ff && !bvalid_ff) begin
        aw_hold_ff <= 1'b0;
        w_hold_ff <= 1'b0;
        bvalid_ff <= 1'b1;
        if (awaddr_ff[3:2] == `SSBD_REG_CTRL >> 2) begin
          bresp_ff <= `SSBD_RESP_OKAY;
          if (wstrb0_ff) begin
            ctrl_ff <= wdata_ff[1:0];
            ctrl_wr_ff <= 1'b1;
            recon_ff <= wdata_ff[`SSBD_CTRL_RECON];
          end
        end else if (awaddr_ff[3:2] == `SSBD_REG_STAT >> 2) begin
          bresp_ff <= `SSBD_RESP_OKAY;
        end else begin
          bresp_ff <= `SSBD_RESP_SLVERR;
        end
      end
      if (bvalid_ff && I_BREADY) begin
        bvalid_ff <= 1'b0;
        awready_ff <= 1'b1;
        wready_ff <= 1'b1;
      end
    end
  end

  // AXI4-Lite read
  always @(posedge I_CLK_SYS or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      arready_ff <= 1'b1;
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h00000000;
      rresp_ff <= `SSBD_RESP_OKAY;
    end else begin
      if (arready_ff && I_ARVALID) begin
        arready_ff <= 1'b0;
        rvalid_ff <= 1'b1;
        rresp_ff <= `SSBD_RESP_OKAY;
        if (I_ARADDR[3:2] == `SSBD_REG_CTRL >> 2) begin
          rdata_ff <= {30'h00000000, ctrl_ff};
        end else if (I_ARADDR[3:2] == `SSBD_REG_STAT >> 2) begin
          rdata_ff <= {16'h0000, frame_cnt_ff, 6'h00, stat_ff[`SSBD_ST_SLEEP], bus_ctrl_ff};
        end else begin
          rdata_ff <= 32'h00000000;
          rresp_ff <= `SSBD_RESP_SLVERR;
        end
      end
      if (rvalid_ff && I_RREADY) begin
        rvalid_ff <= 1'b0;
        arready_ff <= 1'b1;
      end
    end
  end

  assign O_AWREADY = awready_ff;
  assign O_WREADY = wready_ff;
  assign O_BVALID = bvalid_ff;
  assign O_BRESP = bresp_ff;
  assign O_ARREADY = arready_ff;
  assign O_RVALID = rvalid_ff;
  assign O_RDATA = rdata_ff;
  assign O_RRESP = rresp_ff;
  assign O_TX_VALID = tx_valid_ff;
  assign O_TX_BYTE = tx_byte_ff;
  assign O_TX_LAST = tx_last_ff;
  assign O_RF_SEL = rf_sel_ff;
  assign O_CHAIN_SEL = chain_sel_ff;
  assign O_BUS_CTRL = bus_ctrl_ff;

endmodule // ssbd_decoder

// >>> test/ssbd_decoder_asserts.sv
// port checker of the bus-slave command decoder: reply timing, reply hold, selection timing, AXI answers
// assumes one clock and the asynchronous active-low reset of the decoder
`timescale 1ns/1ps
module ssbd_decoder_asserts (
  input wire I_CLK_SYS,
  input wire I_RESET_N,
  input wire I_AWVALID,
  input wire O_AWREADY,
  input wire I_WVALID,
  input wire O_WREADY,
  input wire O_BVALID,
  input wire I_BREADY,
  input wire [3:0] I_ARADDR,
  input wire I_ARVALID,
  input wire O_ARREADY,
  input wire [31:0] O_RDATA,
  input wire [1:0] O_RRESP,
  input wire O_RVALID,
  input wire I_RX_END,
  input wire O_TX_VALID,
  input wire [7:0] O_TX_BYTE,
  input wire O_TX_LAST,
  input wire I_TX_READY,
  input wire [2:0] O_RF_SEL,
  input wire O_CHAIN_SEL,
  input wire O_BUS_CTRL
);
  // cycles since the last frame end; saturates so nothing counts as caused by a frame long gone
  logic [7:0] since_end_ff;
  always @(posedge I_CLK_SYS or negedge I_RESET_N) begin
    if (!I_RESET_N) since_end_ff <= 8'hFF;
    else if (I_RX_END) since_end_ff <= 8'h00;
    else if (since_end_ff != 8'hFF) since_end_ff <= since_end_ff + 8'h01;
  end
  default clocking cb @(posedge I_CLK_SYS); endclocking
  default disable iff (!I_RESET_N);
  a_reply_frame_byte: assert property ($rose(O_TX_VALID) |-> O_TX_BYTE == 8'hE4)
    else $error("reply does not open with the framing byte");
  a_reply_after_end: assert property ($rose(O_TX_VALID) |-> since_end_ff <= 8'h04)
    else $error("reply started without a frame just ended");
  a_reply_hold: assert property (O_TX_VALID && !I_TX_READY |=> O_TX_VALID && $stable(O_TX_BYTE) && $stable(O_TX_LAST))
    else $error("reply byte changed while not taken");
  a_reply_ends: assert property (O_TX_VALID && I_TX_READY && O_TX_LAST |=> !O_TX_VALID)
    else $error("reply continued past its last byte");
  a_sel_after_frame: assert property ($changed(O_RF_SEL) || $changed(O_CHAIN_SEL) |-> since_end_ff <= 8'h05)
    else $error("input selection changed without a frame");
  a_bus_ctrl_frame: assert property ($rose(O_BUS_CTRL) |-> since_end_ff <= 8'h04)
    else $error("bus control taken without a frame");
  a_read_answer: assert property (I_ARVALID && O_ARREADY |=> O_RVALID && !O_ARREADY)
    else $error("read not answered on the next cycle");
  a_write_answer: assert property (I_AWVALID && O_AWREADY && I_WVALID && O_WREADY |-> ##2 O_BVALID)
    else $error("write not answered two cycles after both were taken");
  a_unmapped_read: assert property (I_ARVALID && O_ARREADY && I_ARADDR[3:2] != 2'h0 && I_ARADDR[3:2] != 2'h1
    |=> O_RRESP == 2'h2 && O_RDATA == 32'h0)
    else $error("unmapped read not refused");
  a_write_release: assert property (O_BVALID && I_BREADY |=> !O_BVALID && O_AWREADY && O_WREADY)
    else $error("write channel not released after response");
endmodule // ssbd_decoder_asserts

bind ssbd_decoder ssbd_decoder_asserts ssbd_decoder_asserts_inst (.I_CLK_SYS(I_CLK_SYS), .I_RESET_N(I_RESET_N),
  .I_AWVALID(I_AWVALID), .O_AWREADY(O_AWREADY), .I_WVALID(I_WVALID), .O_WREADY(O_WREADY), .O_BVALID(O_BVALID),
  .I_BREADY(I_BREADY), .I_ARADDR(I_ARADDR), .I_ARVALID(I_ARVALID), .O_ARREADY(O_ARREADY), .O_RDATA(O_RDATA),
  .O_RRESP(O_RRESP), .O_RVALID(O_RVALID), .I_RX_END(I_RX_END), .O_TX_VALID(O_TX_VALID), .O_TX_BYTE(O_TX_BYTE),
  .O_TX_LAST(O_TX_LAST), .I_TX_READY(I_TX_READY), .O_RF_SEL(O_RF_SEL), .O_CHAIN_SEL(O_CHAIN_SEL),
  .O_BUS_CTRL(O_BUS_CTRL));

// >>> test/ssbd_master_model.sv
// behavioural control-bus master: sends frames byte by byte and collects the reply bytes
// assumes the decoder's demodulated byte link on the shared system clock
`timescale 1ns/1ps
module ssbd_master_model (
  input wire logic i_clk,
  input wire logic i_tx_valid,
  input wire logic [7:0] i_tx_byte,
  input wire logic i_tx_last,
  output logic o_rx_valid,
  output logic [7:0] o_rx_byte,
  output logic o_rx_end,
  output logic o_tx_ready
);
  logic [7:0] rpl[$];
  logic slow;
  initial begin
    o_rx_valid = 1'h0;
    o_rx_byte = 8'h00;
    o_rx_end = 1'h0;
    o_tx_ready = 1'h0;
    slow = 1'h0;
  end
  task automatic send(input logic [7:0] b[$]);
    int n;
    rpl.delete();
    foreach (b[i]) begin
      @(posedge i_clk);
      o_rx_valid <= 1'h1;
      o_rx_byte <= b[i];
    end
    @(posedge i_clk);
    o_rx_valid <= 1'h0;
    // idle byte line shows the inverse so a stale byte never passes as fresh
    o_rx_byte <= ~b[b.size() - 1];
    o_rx_end <= 1'h1;
    @(posedge i_clk);
    o_rx_end <= 1'h0;
    for (n = 0; n < 30; n++) begin
      @(posedge i_clk);
      if (i_tx_valid === 1'h1 && o_tx_ready) begin
        rpl.push_back(i_tx_byte);
        if (i_tx_last) break;
      end
      o_tx_ready <= slow ? ~o_tx_ready : 1'h1;
    end
    o_tx_ready <= 1'h0;
    repeat (2) @(posedge i_clk);
  endtask
endmodule // ssbd_master_model

// >>> test/ssbd_decoder_tb.sv
// self-checking bench of the bus-slave command decoder: AXI4-Lite tasks and command frames
// assumes the master model on the frame link and the port checker bound to the decoder
`timescale 1ns/1ps
module ssbd_decoder_tb;
  logic clk = 1'h0, rst_n = 1'h0, volt = 1'h1;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic [3:0] awaddr = 4'h0, araddr = 4'h0, wstrb = 4'hF, p;
  logic [31:0] wdata = 32'h0;
  wire awready, wready, bvalid, arready, rvalid, rx_valid, rx_end, tx_valid, tx_last, tx_ready, chain_sel, bus_ctrl;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  wire [7:0] rx_byte, tx_byte;
  wire [2:0] rf_sel;
  int n_mismatch = 0, tests_run = 0, cyc = 0, i, k, b;
  always #2.5 clk = ~clk;
  ssbd_decoder ssbd_decoder_inst (.I_CLK_SYS(clk), .I_RESET_N(rst_n), .I_AWADDR(awaddr), .I_AWVALID(awvalid),
    .O_AWREADY(awready), .I_WDATA(wdata), .I_WSTRB(wstrb), .I_WVALID(wvalid), .O_WREADY(wready), .O_BRESP(bresp),
    .O_BVALID(bvalid), .I_BREADY(bready), .I_ARADDR(araddr), .I_ARVALID(arvalid), .O_ARREADY(arready),
    .O_RDATA(rdata), .O_RRESP(rresp), .O_RVALID(rvalid), .I_RREADY(rready), .I_RX_VALID(rx_valid),
    .I_RX_BYTE(rx_byte), .I_RX_END(rx_end), .O_TX_VALID(tx_valid), .O_TX_BYTE(tx_byte), .O_TX_LAST(tx_last),
    .I_TX_READY(tx_ready), .I_VOLT_HIGH(volt), .O_RF_SEL(rf_sel), .O_CHAIN_SEL(chain_sel), .O_BUS_CTRL(bus_ctrl));
  ssbd_master_model ssbd_master_model_inst (.i_clk(clk), .i_tx_valid(tx_valid), .i_tx_byte(tx_byte),
    .i_tx_last(tx_last), .o_rx_valid(rx_valid), .o_rx_byte(rx_byte), .o_rx_end(rx_end), .o_tx_ready(tx_ready));
  task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic axw(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'h0;
      if (wvalid && wready) wvalid <= 1'h0;
    end while (bvalid !== 1'h1);
    bready <= 1'h0;
    cmp("bresp", er, bresp);
  endtask
  task automatic axr(input logic [3:0] a, input logic [31:0] ed, input logic [1:0] er, input logic [31:0] m);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'h0;
    end while (rvalid !== 1'h1);
    rready <= 1'h0;
    cmp("rdata", ed, rdata & m);
    cmp("rresp", er, rresp);
  endtask
  // nr: -1 no reply, else number of data bytes after the framing byte
  task automatic fr(input logic [7:0] f, a, c, input logic hd, input logic [7:0] d, input int nr,
    input logic [15:0] ex);
    logic [7:0] fb[$];
    logic [7:0] r[$];
    fb = {f, a, c};
    if (hd) fb.push_back(d);
    ssbd_master_model_inst.send(fb);
    r = ssbd_master_model_inst.rpl;
    cmp("reply count", nr + 1, r.size());
    if (r.size() > 0) cmp("reply frame", `SSBD_FRM_REPLY_OK, r[0]);
    if (r.size() > 1) cmp("reply data", nr == 2 ? ex[15:8] : ex[7:0], r[1]);
    if (r.size() > 2) cmp("reply data2", ex[7:0], r[2]);
  endtask
  task automatic ask(input logic [7:0] c, input int nr, input logic [15:0] ex);
    fr(8'hE3, 8'h10, c, 1'h0, 8'h00, nr, ex);
  endtask
  task summarize;
    $display("counts: %0d compared, %0d mismatched", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      $display("[ERR] run length expected under 20000 seen 20000");
      summarize;
    end
  end
  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1'h1;
    axr(4'h8, 32'h0, 2'h2, 32'hFFFFFFFF);
    axw(4'hC, 32'h7, 2'h2);
    axr(4'h0, 32'h0, 2'h0, 32'hFFFFFFFF);
    axw(4'h0, 32'h2, 2'h0);
    axr(4'h4, 32'h0, 2'h0, 32'hFF);
    cmp("rf_sel", 3'h0, rf_sel);
    cmp("chain_sel", 1'h0, chain_sel);
    $display("test reset_and_bus done");
    fr(8'hE0, 8'h14, 8'h04, 1'h0, 8'h00, -1, 16'h0);
    cmp("bus_ctrl", 1'h1, bus_ctrl);
    ask(8'h10, 1, 16'h0085);
    for (i = 0; i < 8; i++) fr(8'hE0 + i[7:0], 8'h14, 8'h01, 1'h0, 8'h00, (i == 2 || i == 3) ? 0 : -1, 16'h0);
    fr(8'hE8, 8'h14, 8'h06, 1'h0, 8'h00, -1, 16'h0);
    fr(8'hE3, 8'h11, 8'h06, 1'h0, 8'h00, -1, 16'h0);
    fr(8'hE3, 8'h12, 8'h06, 1'h0, 8'h00, -1, 16'h0);
    ask(8'h99, -1, 16'h0);
    ask(8'h10, 1, 16'h0084);
    ask(8'h05, 1, 16'h0014);
    ask(8'h07, 0, 16'h0);
    fr(8'hE3, 8'h10, 8'h08, 1'h1, 8'h15, 0, 16'h0);
    ask(8'h05, 1, 16'h0015);
    ask(8'h06, 0, 16'h0);
    ask(8'h07, 1, 16'h0015);
    ask(8'h05, 0, 16'h0);
    ask(8'h09, -1, 16'h0);
    fr(8'hE3, 8'h10, 8'h09, 1'h1, 8'h14, 0, 16'h0);
    fr(8'hE3, 8'h14, 8'h07, 1'h0, 8'h00, 1, 16'h0014);
    fr(8'hE3, 8'h00, 8'h11, 1'h0, 8'h00, 1, 16'h0003);
    $display("test framing_and_address done");
    p = 4'h0;
    for (k = 0; k < 16; k++) begin
      for (b = 0; b < 4; b++)
        if (k[b] != p[b]) fr(8'hE0, 8'h10, 8'h20 + b[7:0] + (k[b] ? 8'h04 : 8'h00), 1'h0, 8'h00, -1, 16'h0);
      p = k[3:0];
      cmp("rf_sel", {k[2], k[0], k[1]}, rf_sel);
      cmp("chain_sel", k[3], chain_sel);
      ask(8'h14, 1, {8'h00, k[3:0], 4'hF});
    end
    ask(8'h50, 2, 16'h1060);
    ask(8'h51, 1, 16'h0004);
    ask(8'h20, 0, 16'h0);
    ssbd_master_model_inst.slow = 1'h1;
    ask(8'h50, 2, 16'h0975);
    ssbd_master_model_inst.slow = 1'h0;
    ask(8'h51, 1, 16'h0002);
    ask(8'h52, 1, 16'h0002);
    ask(8'h53, 1, 16'h0004);
    ask(8'h38, -1, 16'h0);
    fr(8'hE3, 8'h10, 8'h38, 1'h1, 8'hF5, 0, 16'h0);
    cmp("rf_sel", 3'h6, rf_sel);
    fr(8'hE3, 8'h10, 8'h38, 1'h1, 8'h40, 0, 16'h0);
    cmp("rf_sel", 3'h2, rf_sel);
    $display("test switching done");
    ask(8'h30, 0, 16'h0);
    axr(4'h4, 32'h3, 2'h0, 32'hFF);
    ask(8'h10, -1, 16'h0);
    ask(8'h25, -1, 16'h0);
    ask(8'h31, 0, 16'h0);
    ask(8'h10, 1, 16'h0004);
    cmp("rf_sel", 3'h2, rf_sel);
    ask(8'h00, 0, 16'h0);
    ask(8'h10, 1, 16'h0005);
    cmp("rf_sel", 3'h0, rf_sel);
    axw(4'h0, 32'h1, 2'h0);
    axr(4'h0, 32'h1, 2'h0, 32'h7);
    fr(8'hE3, 8'h14, 8'h24, 1'h0, 8'h00, -1, 16'h0);
    fr(8'hE3, 8'h11, 8'h24, 1'h0, 8'h00, 0, 16'h0);
    cmp("rf_sel", 3'h2, rf_sel);
    axw(4'h0, 32'h5, 2'h0);
    axr(4'h4, 32'h0, 2'h0, 32'h1);
    cmp("bus_ctrl", 1'h0, bus_ctrl);
    volt <= 1'h0;
    ask(8'h10, 1, 16'h0001);
    $display("test sleep_reset_mode done");
    summarize;
  end
endmodule // ssbd_decoder_tb
